// ===== verilog/dlc_pkg.sv
`default_nettype none
package dlc_pkg;
  // ==========================================================
  // register map (word addresses are byte offsets, index * 4)
  localparam logic [3:0] DLC_ADDR_GAIN = 4'h0;
  localparam logic [3:0] DLC_ADDR_TERM = 4'h4;
  localparam logic [3:0] DLC_ADDR_ADJ = 4'h8;
  localparam logic [3:0] DLC_ADDR_STAT = 4'hC;

  // ==========================================================
  // reset values and adjust write mask
  localparam logic [7:0] DLC_GAIN_RST = 8'h0F;
  localparam logic [7:0] DLC_TERM_RST = 8'h08;
  localparam logic [7:0] DLC_ADJ_RST = 8'h00;
  localparam logic [7:0] DLC_ADJ_MASK = 8'h0F;

  // ==========================================================
  // field positions
  localparam int DLC_SQ_BIT = 7;
  localparam int DLC_ARG_HI = 6;
  localparam int DLC_ARG_LO = 4;
  localparam int DLC_ARL_HI = 3;
  localparam int DLC_ARL_LO = 2;
  localparam int DLC_ATL_HI = 1;
  localparam int DLC_ATL_LO = 0;
  localparam int DLC_FULL_BIT = 7;
  localparam int DLC_DCOFF_BIT = 6;
  localparam int DLC_OHS_BIT = 5;
  localparam int DLC_ACT_BIT = 4;
  localparam int DLC_DCT_HI = 3;
  localparam int DLC_DCT_LO = 2;
  localparam int DLC_RZ_BIT = 1;
  localparam int DLC_RT_BIT = 0;
  localparam int DLC_FJ_BIT = 3;
  localparam int DLC_DIAL_BIT = 2;
  localparam int DLC_VOL_BIT = 1;
  localparam int DLC_FLV_BIT = 0;

  // ==========================================================
  // dc termination modes
  localparam logic [1:0] DLC_DCT_LOWV = 2'h0;
  localparam logic [1:0] DLC_DCT_JAPAN = 2'h1;
  localparam logic [1:0] DLC_DCT_USA = 2'h2;
  localparam logic [1:0] DLC_DCT_CLIM = 2'h3;

  // gain in tenths of a dB, signed; mute flagged separately
  // ten bits: -30 dB is -300 tenths, beyond a 9-bit signed range
  typedef logic signed [9:0] dlc_gain_t;

  typedef struct packed {
    logic ring_squelch;
    dlc_gain_t rx_gain;
    dlc_gain_t mon_rx_gain;
    logic mon_rx_mute;
    dlc_gain_t mon_tx_gain;
    logic mon_tx_mute;
    logic full_scale_high;
    logic dc_term_disable;
    logic onhook_slow;
    logic ac_term_complex;
    logic [1:0] dc_term_eff;
    dlc_gain_t tx_level;
    logic ringer_synth;
    logic ring_threshold_high;
    logic dial_headroom;
    logic line_voltage_low;
  } dlc_ctrl_s;
endpackage
`default_nettype wire

// ===== verilog/dlc_decode.sv
`timescale 1ns/100ps
`default_nettype none
module dlc_decode
  import dlc_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // register contents
  input wire logic [7:0] gain_i,
  input wire logic [7:0] term_i,
  input wire logic [7:0] adj_i,
  input wire logic offhook_i,
  // decoded line controls
  output dlc_ctrl_s ctrl_o
);
  dlc_ctrl_s ctrl_d;
  logic [1:0] dc_term_mode;

  // ==========================================================
  // decode helpers
  function automatic dlc_gain_t rx_gain(input logic [2:0] c, input logic off);
    if (off) begin
      case (c)
        3'h0: rx_gain = 10'sd0;
        3'h1: rx_gain = 10'sd30;
        3'h2: rx_gain = 10'sd60;
        3'h3: rx_gain = 10'sd90;
        default: rx_gain = 10'sd120;
      endcase
    end else begin
      case (c)
        3'h0: rx_gain = 10'sd70;
        3'h1: rx_gain = 10'sd60;
        3'h2: rx_gain = 10'sd48;
        3'h3: rx_gain = 10'sd35;
        default: rx_gain = 10'sd20;
      endcase
    end
  endfunction

  // ==========================================================
  // combinational decode
  always_comb begin
    ctrl_d = '0;
    dc_term_mode = term_i[DLC_DCT_HI:DLC_DCT_LO];
    ctrl_d.ring_squelch = gain_i[DLC_SQ_BIT];
    ctrl_d.rx_gain = rx_gain(gain_i[DLC_ARG_HI:DLC_ARG_LO], offhook_i);
    case (gain_i[DLC_ARL_HI:DLC_ARL_LO])
      2'h0: ctrl_d.mon_rx_gain = 10'sd0;
      2'h1: ctrl_d.mon_rx_gain = -10'sd60;
      2'h2: ctrl_d.mon_rx_gain = -10'sd120;
      default: ctrl_d.mon_rx_mute = 1'b1;
    endcase
    case (gain_i[DLC_ATL_HI:DLC_ATL_LO])
      2'h0: ctrl_d.mon_tx_gain = -10'sd180;
      2'h1: ctrl_d.mon_tx_gain = -10'sd240;
      2'h2: ctrl_d.mon_tx_gain = -10'sd300;
      default: ctrl_d.mon_tx_mute = 1'b1;
    endcase
    ctrl_d.full_scale_high = term_i[DLC_FULL_BIT];
    ctrl_d.dc_term_disable = term_i[DLC_DCOFF_BIT];
    ctrl_d.onhook_slow = term_i[DLC_OHS_BIT];
    ctrl_d.ac_term_complex = term_i[DLC_ACT_BIT];
    ctrl_d.ringer_synth = term_i[DLC_RZ_BIT];
    ctrl_d.ring_threshold_high = term_i[DLC_RT_BIT];
    ctrl_d.dial_headroom = adj_i[DLC_DIAL_BIT];
    ctrl_d.line_voltage_low = adj_i[DLC_VOL_BIT];
    // transmit level follows the selected mode, not the forced one
    case (dc_term_mode)
      DLC_DCT_LOWV: ctrl_d.tx_level = -10'sd50;
      DLC_DCT_JAPAN: ctrl_d.tx_level = -10'sd30;
      default: ctrl_d.tx_level = -10'sd10;
    endcase
    if (adj_i[DLC_FJ_BIT]) begin
      ctrl_d.dc_term_eff = DLC_DCT_JAPAN;
    end else if (dc_term_mode == DLC_DCT_USA && adj_i[DLC_FLV_BIT]) begin
      ctrl_d.dc_term_eff = DLC_DCT_LOWV;
    end else begin
      ctrl_d.dc_term_eff = dc_term_mode;
    end
  end

  // ==========================================================
  // registered outputs
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_o <= '0;
    end else begin
      ctrl_o <= ctrl_d;
    end
  end
endmodule // dlc_decode
`default_nettype wire

// ===== verilog/dlc_regs.sv
`timescale 1ns/100ps
`default_nettype none
module dlc_regs
  import dlc_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // line state from the hook logic (pin, synchronised here)
  input wire logic offhook_i,
  // decoded line controls
  output dlc_ctrl_s ctrl_o,
  output logic onhook_dc_off_o
);
  logic [7:0] gain_q;
  logic [7:0] term_q;
  logic [7:0] adj_q;
  logic ack_q;
  logic err_q;
  logic [31:0] rdat_q;
  logic hook_meta_q;
  logic hook_q;
  logic req;
  logic wr;
  logic hit;

  // ==========================================================
  // bus decode; one wait state so ack drops between requests
  assign req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
  assign wr = req && wb_we_i && wb_sel_i[0];
  always_comb begin
    case (wb_adr_i)
      DLC_ADDR_GAIN, DLC_ADDR_TERM, DLC_ADDR_ADJ, DLC_ADDR_STAT: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  assign wb_ack_o = ack_q;
  assign wb_err_o = err_q;
  assign wb_dat_o = rdat_q;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      ack_q <= req && hit;
      err_q <= req && !hit;
    end
  end

  // ==========================================================
  // hook pin synchroniser
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hook_meta_q <= 1'b0;
      hook_q <= 1'b0;
    end else begin
      hook_meta_q <= offhook_i;
      hook_q <= hook_meta_q;
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gain_q <= DLC_GAIN_RST;
      term_q <= DLC_TERM_RST;
      adj_q <= DLC_ADJ_RST;
    end else if (wr) begin
      case (wb_adr_i)
        DLC_ADDR_GAIN: gain_q <= wb_dat_i[7:0];
        DLC_ADDR_TERM: term_q <= wb_dat_i[7:0];
        DLC_ADDR_ADJ: adj_q <= wb_dat_i[7:0] & DLC_ADJ_MASK;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // read data; reserved and upper bits zero
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdat_q <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      case (wb_adr_i)
        DLC_ADDR_GAIN: rdat_q <= {24'h00_0000, gain_q};
        DLC_ADDR_TERM: rdat_q <= {24'h00_0000, term_q};
        DLC_ADDR_ADJ: rdat_q <= {24'h00_0000, adj_q};
        DLC_ADDR_STAT: rdat_q <= {30'h0000_0000, onhook_dc_off_o, hook_q};
        default: rdat_q <= 32'h0000_0000;
      endcase
    end else begin
      rdat_q <= 32'h0000_0000;
    end
  end

  // software misuse flag, visible only; hardware does not override it
  assign onhook_dc_off_o = term_q[DLC_DCOFF_BIT] && !hook_q;

  // ==========================================================
  // field decode
  dlc_decode u_decode (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .gain_i(gain_q),
    .term_i(term_q),
    .adj_i(adj_q),
    .offhook_i(hook_q),
    .ctrl_o(ctrl_o)
  );
endmodule // dlc_regs
`default_nettype wire

// ===== verif/dlc_regs_props.sv
`timescale 1ns/100ps
`default_nettype none
module dlc_regs_props
  import dlc_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  // decoded controls
  input wire dlc_ctrl_s ctrl_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  // a request is only new once the previous answer is gone
  wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire logic wr = req && wb_we_i && wb_sel_i[0];
  // ====
  // bus
  property p_answer; req |=> wb_ack_o != wb_err_o; endproperty
  a_answer: assert property (p_answer) else $error("no single answer");
  property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack too long");
  property p_unmapped; req && wb_adr_i[1:0] != 2'h0 |=> wb_err_o; endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error");
  property p_idle_dat; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_idle_dat: assert property (p_idle_dat) else $error("stray data");
  // ====
  // decode, ctrl lags the stored register by one cycle
  property p_sq; wr && wb_adr_i == DLC_ADDR_GAIN |=> ##1 ctrl_o.ring_squelch == $past(wb_dat_i[7], 2);
  endproperty
  a_sq: assert property (p_sq) else $error("squelch wrong");
  property p_mute;
    wr && wb_adr_i == DLC_ADDR_GAIN |=> ##1 ctrl_o.mon_rx_mute == ($past(wb_dat_i[3:2], 2) == 2'h3) &&
      ctrl_o.mon_tx_mute == ($past(wb_dat_i[1:0], 2) == 2'h3);
  endproperty
  a_mute: assert property (p_mute) else $error("mute wrong");
  property p_term;
    wr && wb_adr_i == DLC_ADDR_TERM |=> ##1 {ctrl_o.full_scale_high, ctrl_o.dc_term_disable, ctrl_o.onhook_slow,
      ctrl_o.ac_term_complex, ctrl_o.ringer_synth, ctrl_o.ring_threshold_high} ==
      $past({wb_dat_i[7:4], wb_dat_i[1:0]}, 2);
  endproperty
  a_term: assert property (p_term) else $error("term bits wrong");
  property p_adj;
    wr && wb_adr_i == DLC_ADDR_ADJ |=> ##1 ctrl_o.line_voltage_low == $past(wb_dat_i[1], 2) &&
      ctrl_o.dial_headroom == $past(wb_dat_i[2], 2);
  endproperty
  a_adj: assert property (p_adj) else $error("adjust bits wrong");
  property p_fj; wr && wb_adr_i == DLC_ADDR_ADJ && wb_dat_i[3] |=> ##1 ctrl_o.dc_term_eff == DLC_DCT_JAPAN;
  endproperty
  a_fj: assert property (p_fj) else $error("japan not forced");
  cover property (wr);
  cover property (req && !wb_we_i ##1 wb_ack_o);
  cover property (wb_err_o);
endmodule // dlc_regs_props
bind dlc_regs dlc_regs_props u_dlc_regs_props (.clock_i, .rstn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .ctrl_o);
`default_nettype wire

// ===== verif/dlc_line_model.sv
`timescale 1ns/100ps
`default_nettype none
module dlc_line_model (
  // clock and hook request
  input wire logic clock_i,
  input wire logic lift_i,
  // hook level toward the device
  output logic offhook_o
);
  // hook moves on an edge; the device resynchronises it anyway
  always_ff @(posedge clock_i) begin
    offhook_o <= lift_i;
  end
endmodule // dlc_line_model
`default_nettype wire

// ===== verif/dlc_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module dlc_regs_tb;
  import dlc_pkg::*;
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, lift = 1'b0, ack, err, offhook, dc_off, last_err;
  logic [3:0] adr = 4'h0, sel = 4'hF;
  logic [31:0] wdat = 32'h0, dat_o, rd;
  dlc_ctrl_s ctrl;
  int err_total = 0, checks_done = 0, i;
  dlc_gain_t on_t [8] = '{70, 60, 48, 35, 20, 20, 20, 20};
  dlc_gain_t off_t [8] = '{0, 30, 60, 90, 120, 120, 120, 120};
  dlc_gain_t mrx [3] = '{0, -60, -120};
  dlc_gain_t mtx [3] = '{-180, -240, -300};
  dlc_gain_t txl [4] = '{-50, -30, -10, -10};
  initial begin
    forever #20 clock_i = ~clock_i;
  end
  dlc_regs u_dlc_regs (.clock_i, .rstn_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err), .offhook_i(offhook),
    .ctrl_o(ctrl), .onhook_dc_off_o(dc_off));
  dlc_line_model u_dlc_line_model (.clock_i, .lift_i(lift), .offhook_o(offhook));
  // ====
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    if (err_total == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one classic cycle, then an idle edge so requests never merge
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clock_i);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      test_done();
    end
    rd = dat_o;
    last_err = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clock_i);
  endtask
  // ====
  // sequence
  initial begin
    repeat (2) @(posedge clock_i);
    rstn_i <= 1'b1;
    @(posedge clock_i);
    wb(1'b0, DLC_ADDR_GAIN, 8'h00); chk(rd, 32'h0000000F);
    wb(1'b0, DLC_ADDR_TERM, 8'h00); chk(rd, 32'h00000008);
    wb(1'b0, DLC_ADDR_ADJ, 8'h00); chk(rd, 32'h00000000);
    wb(1'b1, DLC_ADDR_ADJ, 8'hFF);
    wb(1'b0, DLC_ADDR_ADJ, 8'h00); chk(rd, 32'h0000000F);
    sel <= 4'hE;
    wb(1'b1, DLC_ADDR_GAIN, 8'h00);
    sel <= 4'hF;
    wb(1'b0, DLC_ADDR_GAIN, 8'h00); chk(rd, 32'h0000000F);
    wb(1'b0, 4'h1, 8'h00); chk(last_err, 1'b1);
    for (i = 0; i < 16; i++) begin
      if (i == 8) begin
        lift <= 1'b1;
        repeat (6) @(posedge clock_i);
      end
      wb(1'b1, DLC_ADDR_GAIN, {i[0], i[2:0], 4'h0});
      chk(ctrl.ring_squelch, i[0]);
      chk(ctrl.rx_gain, i < 8 ? on_t[i] : off_t[i - 8]);
    end
    for (i = 0; i < 4; i++) begin
      wb(1'b1, DLC_ADDR_GAIN, {4'h0, i[1:0], i[1:0]});
      chk({ctrl.mon_rx_mute, ctrl.mon_tx_mute}, i == 3 ? 2'h3 : 2'h0);
      if (i < 3) chk({ctrl.mon_rx_gain, ctrl.mon_tx_gain}, {mrx[i], mtx[i]});
      wb(1'b1, DLC_ADDR_ADJ, 8'h00);
      wb(1'b1, DLC_ADDR_TERM, {4'h0, i[1:0], 2'h0});
      chk(ctrl.dc_term_eff, i[1:0]);
      chk(ctrl.tx_level, txl[i]);
    end
    wb(1'b1, DLC_ADDR_TERM, 8'h08);
    wb(1'b1, DLC_ADDR_ADJ, 8'h01); chk({ctrl.dc_term_eff, ctrl.tx_level}, {DLC_DCT_LOWV, txl[2]});
    wb(1'b1, DLC_ADDR_ADJ, 8'h09); chk(ctrl.dc_term_eff, DLC_DCT_JAPAN);
    wb(1'b1, DLC_ADDR_TERM, 8'hAF);
    chk({ctrl.full_scale_high, ctrl.dc_term_disable, ctrl.onhook_slow, ctrl.ac_term_complex, ctrl.ringer_synth,
      ctrl.ring_threshold_high}, 6'h2B);
    wb(1'b1, DLC_ADDR_ADJ, 8'h04); chk(ctrl.dial_headroom, 1'b1);
    wb(1'b1, DLC_ADDR_TERM, 8'h50);
    chk({ctrl.full_scale_high, ctrl.dc_term_disable, ctrl.onhook_slow, ctrl.ac_term_complex, ctrl.ringer_synth,
      ctrl.ring_threshold_high}, 6'h14);
    chk(dc_off, 1'b0);
    wb(1'b0, DLC_ADDR_STAT, 8'h00); chk(rd, 32'h00000001);
    lift <= 1'b0;
    repeat (6) @(posedge clock_i);
    chk(dc_off, 1'b1);
    wb(1'b0, DLC_ADDR_STAT, 8'h00); chk(rd, 32'h00000002);
    test_done();
  end
endmodule // dlc_regs_tb
`default_nettype wire
